/* src/aalo_pkg.sv */
// Shared constants and types for the accumulator add/logic execution block.
// Assumes a single 40 MHz core clock and a synchronous active-high reset.

package aalo_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W   = 5;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned BYTE_W   = 8;
  localparam int unsigned BE_W     = 4;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ACC_OFS  = 5'h00;
  localparam logic [ADDR_W-1:0] MEM_OFS  = 5'h04;
  localparam logic [ADDR_W-1:0] IMM_OFS  = 5'h08;
  localparam logic [ADDR_W-1:0] STAT_OFS = 5'h0C;
  localparam logic [ADDR_W-1:0] CMD_OFS  = 5'h10;

  // ----------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------
  localparam int unsigned CARRY_BIT = 0;
  localparam int unsigned HALF_BIT  = 1;
  localparam int unsigned ZERO_BIT  = 2;
  localparam int unsigned OVF_BIT   = 3;
  localparam int unsigned FLAGS_W   = 4;
  localparam int unsigned OP_W      = 3;
  localparam int unsigned NIB_W     = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [BYTE_W-1:0] BYTE_RST  = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Operation codes
  // ----------------------------------------------------------------
  typedef enum logic [OP_W-1:0] {
    SUM_CARRY_INTO_ACC     = 3'h0,
    SUM_CARRY_INTO_MEM     = 3'h1,
    SUM_INTO_ACC           = 3'h2,
    SUM_IMM_INTO_ACC       = 3'h3,
    SUM_INTO_MEM           = 3'h4,
    BITWISE_MASK_INTO_ACC  = 3'h5,
    BITWISE_MASK_IMM_INTO_ACC = 3'h6,
    BITWISE_MASK_INTO_MEM  = 3'h7
  } aalo_op_type;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_EXEC = 3'b100
  } aalo_state_type;

endpackage : aalo_pkg

/* src/aalo_adder.sv */
// Eight-bit adder with carry, half-carry and signed overflow outputs.
// Assumes operands arrive from flip-flops on the same clock.

module aalo_adder
  import aalo_pkg::*;
(
  input  wire logic [BYTE_W-1:0] a_i,
  input  wire logic [BYTE_W-1:0] b_i,
  input  wire logic              cin_i,
  output logic      [BYTE_W-1:0] sum_o,
  output logic                   carry_o,
  output logic                   half_o,
  output logic                   ovf_o
);

  // ----------------------------------------------------------------
  // Sum and flags
  // ----------------------------------------------------------------
  logic [BYTE_W:0] full;
  logic [NIB_W:0]  low;

  always_comb
  begin
    full    = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin_i};
    low     = {1'b0, a_i[NIB_W-1:0]} + {1'b0, b_i[NIB_W-1:0]} + {4'h0, cin_i};
    sum_o   = full[BYTE_W-1:0];
    carry_o = full[BYTE_W];                                         // RULE9
    half_o  = low[NIB_W];                                           // RULE9
    ovf_o   = (a_i[BYTE_W-1] == b_i[BYTE_W-1]) &&
              (full[BYTE_W-1] != a_i[BYTE_W-1]);                    // RULE9
  end

endmodule : aalo_adder

/* src/aalo_core.sv */
// Accumulator add / AND execution unit with an Avalon-MM register slave.
// Assumes an Avalon-MM master on sys_clk_i that holds requests while waitrequest is high.
// What this block does
// RULE1: Add with carry into the accumulator sums acc, memory byte and carry and sets all four flags.
// RULE2: Add with carry into memory writes acc plus byte plus carry back to memory, acc kept.
// RULE3: Plain add into the accumulator sums acc and memory byte without carry, all four flags.
// RULE4: Immediate add sums acc and the literal into the accumulator, all four flags.
// RULE5: Add into memory writes acc plus byte back to memory and sets all four flags.
// RULE6: AND into the accumulator with the memory byte changes only the zero flag.
// RULE7: AND of acc with the literal into the accumulator changes only the zero flag.
// RULE8: AND into memory writes acc AND byte back to memory and changes only the zero flag.
// RULE9: Carry is bit 7 carry out, half carry is bit 3 carry out, overflow is signed, zero is all zero.

module aalo_core
  import aalo_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [DATA_W-1:0] avs_writedata_i,
  input  wire logic [BE_W-1:0]   avs_byteenable_i,
  output logic      [DATA_W-1:0] avs_readdata_o,
  output logic                   avs_waitrequest_o,
  output logic      [BYTE_W-1:0] acc_o,
  output logic      [BYTE_W-1:0] mem_o,
  output logic                   carry_flag_o,
  output logic                   half_carry_flag_o,
  output logic                   zero_flag_o,
  output logic                   signed_overflow_flag_o
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    aalo_state_type    state;
    aalo_op_type       op;
    logic [BYTE_W-1:0] acc;
    logic [BYTE_W-1:0] mem;
    logic [BYTE_W-1:0] imm;
    logic              carry;
    logic              half;
    logic              zero;
    logic              ovf;
    logic [DATA_W-1:0] rdata;
  } aalo_regs_type;

  aalo_regs_type regs_ff;
  aalo_regs_type nxt_regs;

  // ----------------------------------------------------------------
  // Operation decode
  // ----------------------------------------------------------------
  function automatic logic op_uses_carry(input aalo_op_type op);
    op_uses_carry = (op == SUM_CARRY_INTO_ACC) || (op == SUM_CARRY_INTO_MEM);
  endfunction : op_uses_carry

  function automatic logic op_uses_imm(input aalo_op_type op);
    op_uses_imm = (op == SUM_IMM_INTO_ACC) || (op == BITWISE_MASK_IMM_INTO_ACC);
  endfunction : op_uses_imm

  function automatic logic op_is_mask(input aalo_op_type op);
    op_is_mask = (op == BITWISE_MASK_INTO_ACC) || (op == BITWISE_MASK_IMM_INTO_ACC) ||
                 (op == BITWISE_MASK_INTO_MEM);
  endfunction : op_is_mask

  function automatic logic op_to_mem(input aalo_op_type op);
    op_to_mem = (op == SUM_CARRY_INTO_MEM) || (op == SUM_INTO_MEM) ||
                (op == BITWISE_MASK_INTO_MEM);
  endfunction : op_to_mem

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  logic [BYTE_W-1:0] operand_b;
  logic              carry_in;
  logic [BYTE_W-1:0] add_sum;
  logic              add_carry;
  logic              add_half;
  logic              add_ovf;
  logic [BYTE_W-1:0] result;

  always_comb
  begin
    operand_b = op_uses_imm(regs_ff.op) ? regs_ff.imm : regs_ff.mem;         // RULE4 RULE7
    carry_in  = op_uses_carry(regs_ff.op) ? regs_ff.carry : 1'b0;            // RULE1 RULE3
    result    = op_is_mask(regs_ff.op) ? (regs_ff.acc & operand_b) : add_sum; // RULE6
  end

  aalo_adder u_adder (
    .a_i     (regs_ff.acc),
    .b_i     (operand_b),
    .cin_i   (carry_in),
    .sum_o   (add_sum),
    .carry_o (add_carry),
    .half_o  (add_half),
    .ovf_o   (add_ovf)
  );

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  function automatic logic [DATA_W-1:0] read_word(input aalo_regs_type r,
                                                  input logic [ADDR_W-1:0] addr);
    logic [DATA_W-1:0] w;
    w = RDATA_RST;
    case (addr)
      ACC_OFS:  w[BYTE_W-1:0] = r.acc;
      MEM_OFS:  w[BYTE_W-1:0] = r.mem;
      IMM_OFS:  w[BYTE_W-1:0] = r.imm;
      STAT_OFS:
      begin
        w[CARRY_BIT] = r.carry;
        w[HALF_BIT]  = r.half;
        w[ZERO_BIT]  = r.zero;
        w[OVF_BIT]   = r.ovf;
      end
      CMD_OFS:  w[OP_W-1:0] = r.op;
      default:  w = RDATA_RST;
    endcase
    read_word = w;
  endfunction : read_word

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_regs = regs_ff;
    case (regs_ff.state)
      ST_IDLE:
      begin
        if (avs_write_i)
        begin
          if (avs_byteenable_i[0])
          begin
            case (avs_address_i)
              ACC_OFS:  nxt_regs.acc = avs_writedata_i[BYTE_W-1:0];
              MEM_OFS:  nxt_regs.mem = avs_writedata_i[BYTE_W-1:0];
              IMM_OFS:  nxt_regs.imm = avs_writedata_i[BYTE_W-1:0];
              STAT_OFS:
              begin
                nxt_regs.carry = avs_writedata_i[CARRY_BIT];
                nxt_regs.half  = avs_writedata_i[HALF_BIT];
                nxt_regs.zero  = avs_writedata_i[ZERO_BIT];
                nxt_regs.ovf   = avs_writedata_i[OVF_BIT];
              end
              CMD_OFS:
              begin
                nxt_regs.op    = aalo_op_type'(avs_writedata_i[OP_W-1:0]);
                nxt_regs.state = ST_EXEC;
              end
              default: nxt_regs.state = ST_IDLE;
            endcase
          end
        end
        else if (avs_read_i)
        begin
          nxt_regs.rdata = read_word(regs_ff, avs_address_i);
          nxt_regs.state = ST_READ;
        end
      end
      ST_READ:
      begin
        nxt_regs.state = ST_IDLE;
      end
      ST_EXEC:
      begin
        if (op_to_mem(regs_ff.op))
          nxt_regs.mem = result;                                    // RULE2 RULE5 RULE8
        else
          nxt_regs.acc = result;                                    // RULE1 RULE3 RULE4 RULE6 RULE7
        nxt_regs.zero = (result == BYTE_RST);                       // RULE9
        if (!op_is_mask(regs_ff.op))
        begin
          nxt_regs.carry = add_carry;                               // RULE9
          nxt_regs.half  = add_half;                                // RULE9
          nxt_regs.ovf   = add_ovf;                                 // RULE9
        end
        nxt_regs.state = ST_IDLE;
      end
      default:
      begin
        nxt_regs.state = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      regs_ff.state <= ST_IDLE;
      regs_ff.op    <= SUM_CARRY_INTO_ACC;
      regs_ff.acc   <= BYTE_RST;
      regs_ff.mem   <= BYTE_RST;
      regs_ff.imm   <= BYTE_RST;
      regs_ff.carry <= 1'b0;
      regs_ff.half  <= 1'b0;
      regs_ff.zero  <= 1'b0;
      regs_ff.ovf   <= 1'b0;
      regs_ff.rdata <= RDATA_RST;
    end
    else
    begin
      regs_ff <= nxt_regs;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb
  begin
    avs_waitrequest_o = (avs_read_i || avs_write_i) &&
                        !((regs_ff.state == ST_IDLE) && avs_write_i) &&
                        !((regs_ff.state == ST_READ) && avs_read_i);
  end

  assign avs_readdata_o         = regs_ff.rdata;
  assign acc_o                  = regs_ff.acc;
  assign mem_o                  = regs_ff.mem;
  assign carry_flag_o           = regs_ff.carry;
  assign half_carry_flag_o      = regs_ff.half;
  assign zero_flag_o            = regs_ff.zero;
  assign signed_overflow_flag_o = regs_ff.ovf;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  logic [BYTE_W:0]  h_adc;
  logic [BYTE_W:0]  h_add;
  logic [BYTE_W:0]  h_addi;
  logic [NIB_W:0]   h_low;
  logic             h_exec;
  logic [FLAGS_W-2:0] h_flags;

  always_comb
  begin
    h_adc   = {1'b0, regs_ff.acc} + {1'b0, regs_ff.mem} + {8'h00, regs_ff.carry};
    h_add   = {1'b0, regs_ff.acc} + {1'b0, regs_ff.mem};
    h_addi  = {1'b0, regs_ff.acc} + {1'b0, regs_ff.imm};
    h_low   = {1'b0, regs_ff.acc[NIB_W-1:0]} + {1'b0, regs_ff.mem[NIB_W-1:0]};
    h_exec  = (regs_ff.state == ST_EXEC);
    h_flags = {regs_ff.ovf, regs_ff.half, regs_ff.carry};
  end

  a_adc_acc_sum: assert property (h_exec && regs_ff.op == SUM_CARRY_INTO_ACC |=> // RULE1
    acc_o == $past(h_adc[BYTE_W-1:0]) && carry_flag_o == $past(h_adc[BYTE_W]) &&
    $stable(mem_o))
    else $error("add with carry into acc wrong");

  a_adc_mem_sum: assert property (h_exec && regs_ff.op == SUM_CARRY_INTO_MEM |=> // RULE2
    mem_o == $past(h_adc[BYTE_W-1:0]) && $stable(acc_o) &&
    carry_flag_o == $past(h_adc[BYTE_W]))
    else $error("add with carry into memory wrong");

  a_add_acc_sum: assert property (h_exec && regs_ff.op == SUM_INTO_ACC |=> // RULE3
    acc_o == $past(h_add[BYTE_W-1:0]) && carry_flag_o == $past(h_add[BYTE_W]))
    else $error("plain add into acc wrong");

  a_add_imm_sum: assert property (h_exec && regs_ff.op == SUM_IMM_INTO_ACC |=> // RULE4
    acc_o == $past(h_addi[BYTE_W-1:0]) && carry_flag_o == $past(h_addi[BYTE_W]))
    else $error("immediate add wrong");

  a_add_mem_sum: assert property (h_exec && regs_ff.op == SUM_INTO_MEM |=> // RULE5
    mem_o == $past(h_add[BYTE_W-1:0]) && $stable(acc_o) &&
    zero_flag_o == (mem_o == BYTE_RST))
    else $error("add into memory wrong");

  a_and_acc_only: assert property (h_exec && regs_ff.op == BITWISE_MASK_INTO_ACC |=> // RULE6
    acc_o == $past(regs_ff.acc & regs_ff.mem) && h_flags == $past(h_flags) &&
    zero_flag_o == (acc_o == BYTE_RST))
    else $error("and into acc wrong");

  a_and_imm_only: assert property (h_exec && regs_ff.op == BITWISE_MASK_IMM_INTO_ACC |=> // RULE7
    acc_o == $past(regs_ff.acc & regs_ff.imm) && h_flags == $past(h_flags))
    else $error("and immediate wrong");

  a_and_mem_only: assert property (h_exec && regs_ff.op == BITWISE_MASK_INTO_MEM |=> // RULE8
    mem_o == $past(regs_ff.acc & regs_ff.mem) && h_flags == $past(h_flags) &&
    $stable(acc_o))
    else $error("and into memory wrong");

  a_half_ovf_flag: assert property (h_exec && regs_ff.op == SUM_INTO_ACC |=> // RULE9
    half_carry_flag_o == $past(h_low[NIB_W]) &&
    signed_overflow_flag_o == $past((regs_ff.acc[BYTE_W-1] == regs_ff.mem[BYTE_W-1]) &&
                                    (h_add[BYTE_W-1] != regs_ff.acc[BYTE_W-1])))
    else $error("half carry or overflow wrong");

  a_zero_acc_flag: assert property (h_exec && !op_to_mem(regs_ff.op) |=> // RULE9
    zero_flag_o == (acc_o == BYTE_RST))
    else $error("zero flag wrong");

  a_read_answer: assert property (avs_read_i && regs_ff.state == ST_IDLE |=>
    !avs_waitrequest_o ##1 regs_ff.state == ST_IDLE)
    else $error("read answer late");

  c_adc_carry_out: cover property (h_exec && regs_ff.op == SUM_CARRY_INTO_ACC && h_adc[BYTE_W]);
  c_mem_write_back: cover property (h_exec && op_to_mem(regs_ff.op));
  c_and_zero: cover property (h_exec && op_is_mask(regs_ff.op) && result == BYTE_RST);
  c_signed_ovf: cover property (h_exec && add_ovf && !op_is_mask(regs_ff.op));

endmodule : aalo_core

/* sim/aalo_bus_model.sv */
// Avalon-MM master standing in for the decode stage driving the block.
// Assumes the slave answers on its own waitrequest; waits are not bounded here.

module aalo_bus_model
  import aalo_pkg::*;
(
  input  wire logic              sys_clk_i,
  output logic      [ADDR_W-1:0] avs_address_o,
  output logic                   avs_read_o,
  output logic                   avs_write_o,
  output logic      [DATA_W-1:0] avs_writedata_o,
  output logic      [BE_W-1:0]   avs_byteenable_o,
  input  wire logic [DATA_W-1:0] avs_readdata_i,
  input  wire logic              avs_waitrequest_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Idle bus
  // ----------------------------------------------------------------
  initial
  begin
    avs_address_o    = '0;
    avs_read_o       = 1'b0;
    avs_write_o      = 1'b0;
    avs_writedata_o  = '0;
    avs_byteenable_o = '0;
  end

  // ----------------------------------------------------------------
  // One transfer, held until waitrequest is low at a rising edge
  // ----------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] adr,
                      input logic [DATA_W-1:0] wd, input logic [BE_W-1:0] be,
                      output logic [DATA_W-1:0] rd);
    rd = '0;
    avs_address_o    <= adr;
    avs_write_o      <= wr;
    avs_read_o       <= !wr;
    avs_writedata_o  <= wd;
    avs_byteenable_o <= be;
    do
      @(posedge sys_clk_i);
    while (avs_waitrequest_i !== 1'b0);
    rd = avs_readdata_i;
    avs_read_o  <= 1'b0;
    avs_write_o <= 1'b0;
    @(posedge sys_clk_i);
  endtask : xfer

endmodule : aalo_bus_model

/* sim/accumulator_add_logic_ops_bench.sv */
// Self-checking bench for the accumulator add / AND execution unit.
// Assumes aalo_core with the register map of aalo_pkg and a bus model master.

module accumulator_add_logic_ops_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import aalo_pkg::*;

  logic              sys_clk;
  logic              sys_rst;
  logic [ADDR_W-1:0] address;
  logic              rd_req;
  logic              wr_req;
  logic [DATA_W-1:0] wdata;
  logic [BE_W-1:0]   be;
  logic [DATA_W-1:0] rdata;
  logic              waitreq;
  logic [BYTE_W-1:0] acc_o;
  logic [BYTE_W-1:0] mem_o;
  logic              c_f, h_f, z_f, v_f;
  int                error_cnt = 0;
  int                n_checks = 0;
  logic [DATA_W-1:0] d;

  aalo_core aalo_core_i (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .avs_address_i(address),
    .avs_read_i(rd_req), .avs_write_i(wr_req), .avs_writedata_i(wdata),
    .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .acc_o(acc_o), .mem_o(mem_o), .carry_flag_o(c_f), .half_carry_flag_o(h_f),
    .zero_flag_o(z_f), .signed_overflow_flag_o(v_f));

  aalo_bus_model aalo_bus_model_i (.sys_clk_i(sys_clk), .avs_address_o(address),
    .avs_read_o(rd_req), .avs_write_o(wr_req), .avs_writedata_o(wdata),
    .avs_byteenable_o(be), .avs_readdata_i(rdata), .avs_waitrequest_i(waitreq));

  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Checking and bus helpers
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    logic [DATA_W-1:0] dummy;
    aalo_bus_model_i.xfer(1'b1, a, v, {3'($urandom()), 1'b1}, dummy);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    aalo_bus_model_i.xfer(1'b0, a, '0, 4'hF, v);
  endtask : rd

  // ----------------------------------------------------------------
  // Expected {acc, mem, flags} after one operation
  // ----------------------------------------------------------------
  function automatic logic [19:0] expect_op(input logic [OP_W-1:0] op,
    input logic [BYTE_W-1:0] a, input logic [BYTE_W-1:0] m,
    input logic [BYTE_W-1:0] i, input logic [FLAGS_W-1:0] f);
    logic [BYTE_W-1:0]  b, r;
    logic [BYTE_W:0]    s;
    logic [NIB_W:0]     h;
    logic               cin, to_mem;
    logic [FLAGS_W-1:0] nf;
    b = (op == 3'h3 || op == 3'h6) ? i : m;
    cin = (op <= 3'h1) ? f[CARRY_BIT] : 1'b0;
    s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    nf = f;
    r = a & b;
    if (op <= 3'h4)
    begin
      r = s[7:0];
      nf[CARRY_BIT] = s[8];
      nf[HALF_BIT] = h[4];
      nf[OVF_BIT] = (a[7] == b[7]) && (r[7] != a[7]);
    end
    nf[ZERO_BIT] = (r == 8'h00);
    to_mem = (op == 3'h1 || op == 3'h4 || op == 3'h7);
    return {to_mem ? a : r, to_mem ? r : m, nf};
  endfunction : expect_op

  // ----------------------------------------------------------------
  // Load operands and flags, run one operation, compare everything
  // ----------------------------------------------------------------
  task automatic run_op(input logic [OP_W-1:0] op, input logic [BYTE_W-1:0] a,
    input logic [BYTE_W-1:0] m, input logic [BYTE_W-1:0] i, input logic [FLAGS_W-1:0] f);
    logic [19:0]       e;
    logic [DATA_W-1:0] v;
    e = expect_op(op, a, m, i, f);
    wr(ACC_OFS, {24'h0, a});
    wr(MEM_OFS, {24'h0, m});
    wr(IMM_OFS, {24'h0, i});
    wr(STAT_OFS, {28'h0, f});
    wr(CMD_OFS, {29'h0, op});
    rd(STAT_OFS, v);
    check("status", v, {28'h0, e[3:0]});
    check("acc", {24'h0, acc_o}, {24'h0, e[19:12]});
    check("mem", {24'h0, mem_o}, {24'h0, e[11:4]});
    check("flags", {28'h0, v_f, z_f, h_f, c_f}, {28'h0, e[3:0]});
    rd(MEM_OFS, v);
    check("mem read", v, {24'h0, e[11:4]});
    rd(CMD_OFS, v);
    check("last op", v, {29'h0, op});
  endtask : run_op

  task automatic report_and_stop();
    if (error_cnt == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    error_cnt++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    void'($urandom(27));
    for (int k = 0; k < 5; k++)
    begin
      rd(ADDR_W'(k * 4), d);
      check("reset value", d, RDATA_RST);
    end
    check("reset acc", {24'h0, acc_o}, {24'h0, BYTE_RST});
    run_op(3'h0, 8'hFF, 8'h00, 8'h11, 4'h1);
    run_op(3'h1, 8'h0F, 8'h00, 8'h22, 4'h1);
    run_op(3'h2, 8'h80, 8'h80, 8'h33, 4'h0);
    run_op(3'h3, 8'h7F, 8'h44, 8'h01, 4'h1);
    run_op(3'h4, 8'h00, 8'h00, 8'h55, 4'hF);
    run_op(3'h5, 8'hF0, 8'h0F, 8'h66, 4'hB);
    run_op(3'h6, 8'hA5, 8'h77, 8'h3C, 4'hF);
    run_op(3'h7, 8'hC3, 8'h81, 8'h88, 4'h5);
    wr(ACC_OFS, 32'h0000_003C);
    aalo_bus_model_i.xfer(1'b1, ACC_OFS, 32'h0000_0055, 4'hE, d);
    rd(ACC_OFS, d);
    check("masked write", d, 32'h0000_003C);
    wr(IMM_OFS, 32'hFFFF_FFAB);
    rd(IMM_OFS, d);
    check("upper bits", d, 32'h0000_00AB);
    wr(5'h14, 32'h0000_00FF);
    rd(5'h14, d);
    check("unmapped", d, 32'h0000_0000);
    for (int n = 0; n < 250; n++)
      run_op(3'($urandom()), 8'($urandom()), 8'($urandom()), 8'($urandom()), 4'($urandom()));
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    check("acc after reset", {24'h0, acc_o}, {24'h0, BYTE_RST});
    check("flags after reset", {28'h0, v_f, z_f, h_f, c_f}, 32'h0000_0000);
    run_op(3'h0, 8'h7F, 8'h7F, 8'h00, 4'h1);
    report_and_stop();
  end

endmodule : accumulator_add_logic_ops_bench
